// ---- verilog/pecb_core.sv ----
// Boot-memory error correction path with checkbit bypass and APB registers
//
// Summary of operation
// - Shortened 39-bit code: correct one, detect two
// - Compute seven check bits, verify on read
// - Single error: corrected data, normal completion
// - Double error: end transfer with error
// - Checking only while protection enable set
// - 32-bit mode: check bits on checkbit bus
// - Checkbit bus only with protection and 32-bit
// - 8-bit protected mode: four-byte word access
// - 8-bit check byte at inverted word address
// - Write bypass drives test field on writes
// - Read bypass captures raw check bits
// - Read bypass capture needs protection enabled
// - Protection off: never a mismatch error
//
// The APB interface to the registers and the address map are this design's own decisions.
`include "pecb_regs.svh"

module pecb_core
   import pecb_pkg::*;
(
   input wire logic core_clk_i,
   input wire logic rst_i,
   // APB slave
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [11:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   output logic irq_o,
   // On-chip master request port
   input wire logic req_valid_i,
   input wire logic req_write_i,
   input wire logic [27:0] req_addr_i,
   input wire logic [31:0] req_wdata_i,
   output logic req_ready_o,
   output logic resp_valid_o,
   output logic resp_err_o,
   output logic [31:0] resp_rdata_o,
   // External memory pins
   output logic [27:0] mem_addr_o,
   output logic mem_cs_n_o,
   output logic mem_oe_n_o,
   output logic mem_we_n_o,
   input wire logic [31:0] mem_data_i,
   output logic [31:0] mem_data_o,
   output logic mem_data_oe_o,
   input wire logic [7:0] chkbus_i,
   output logic [7:0] chkbus_o,
   output logic chkbus_oe_o
);

   // ****************************************************************
   // Declarations
   // ****************************************************************
   localparam logic [1:0] CYC_LAST = 2'(`PECB_MEM_CYC - 1);

   pecb_state_e state; // Sequencer state
   pecb_state_e next_state; // Its next value
   logic [31:0] cfg3; // memory_config_reg_three
   logic [1:0] status; // Sticky event bits
   logic [1:0] mask; // Interrupt mask
   logic is_write; // Latched direction
   logic [27:0] addr; // Latched byte address
   logic [31:0] wdata; // Latched write data
   logic [31:0] rdata; // Raw read data gathered
   pecb_check_t rcheck; // Raw check bits sampled
   pecb_check_t wcheck_gen; // Generated from write data
   pecb_check_t rcheck_gen; // Regenerated from read data
   logic [1:0] byte_cnt; // Byte lane in 8-bit mode
   logic [1:0] cyc_cnt; // Cycles inside one memory cycle
   pecb_check_t test_field; // test_checkbit_field

   // ****************************************************************
   // Configuration fields
   // ****************************************************************
   wire prot_en = cfg3[`PECB_CFG_PROT_EN];
   wire write_checkbit_bypass = cfg3[`PECB_CFG_WR_BYP];
   wire read_checkbit_bypass = cfg3[`PECB_CFG_RD_BYP];
   wire bus8 = cfg3[`PECB_CFG_BUS8];
   assign test_field = cfg3[`PECB_CFG_FIELD_HI:`PECB_CFG_FIELD_LO];

   // ****************************************************************
   // APB decode
   // ****************************************************************
   wire apb_acc = psel_i & penable_i;
   wire hit_cfg = paddr_i == `PECB_OFS_CFG3;
   wire hit_st = paddr_i == `PECB_OFS_STATUS;
   wire hit_mask = paddr_i == `PECB_OFS_MASK;
   wire hit_any = hit_cfg | hit_st | hit_mask;
   wire wr_cfg = apb_acc & pwrite_i & hit_cfg;
   wire wr_mask = apb_acc & pwrite_i & hit_mask;
   wire rd_st = apb_acc & ~pwrite_i & hit_st;
   // Writable bits only; reserved bits stay zero
   wire [31:0] cfg_wmask = 32'h0000_7F0F;

   // Zero wait states: every access completes in its access phase
   assign pready_o = 1'b1;
   assign pslverr_o = apb_acc & ~hit_any;
   assign prdata_o = hit_cfg ? cfg3 :
                     hit_st ? {30'h0, status} :
                     hit_mask ? {30'h0, mask} : 32'h0000_0000;
   assign irq_o = |(status & mask);

   // ****************************************************************
   // Check-bit generators
   // ****************************************************************
   // Write side: from latched write data
   pecb_check_gen u_gen_wr (
      .data_i(wdata),
      .check_o(wcheck_gen)
   );

   // Read side: from raw gathered read data
   pecb_check_gen u_gen_rd (
      .data_i(rdata),
      .check_o(rcheck_gen)
   );

   // ****************************************************************
   // Syndrome decode
   // ****************************************************************
   wire [6:0] syndrome = rcheck ^ rcheck_gen;
   wire syn_zero = syndrome == 7'h00;
   wire syn_check_bit = $countones(syndrome) == 1;
   logic [31:0] flip; // Data bit whose column matches
   always_comb begin
      for (int i = 0; i < 32; i++) begin
         flip[i] = syndrome == pecb_col(i);
      end
   end
   // Correctable: one data bit or one check bit in error
   wire correctable = (|flip) | syn_check_bit;
   wire single_err = prot_en & ~syn_zero & correctable;
   // Anything else nonzero is at least two bits in error
   wire double_err = prot_en & ~syn_zero & ~correctable;
   wire [31:0] corr_data = prot_en ? (rdata ^ flip) : rdata;

   // ****************************************************************
   // Sequencer control terms
   // ****************************************************************
   wire cyc_end = cyc_cnt == CYC_LAST;
   wire last_data = ~bus8 | (byte_cnt == 2'h3);
   wire use_chkbus = prot_en & ~bus8;
   wire need_check_byte = prot_en & bus8;
   // Check value actually written: bypass field or fresh code
   wire [6:0] wr_check = write_checkbit_bypass ? test_field : wcheck_gen;
   wire sample_data = (state == ST_DATA) & cyc_end & ~is_write;
   wire sample_check = ~is_write & cyc_end & ((state == ST_DATA) & use_chkbus |
                       (state == ST_CHECK));
   // Raw check bits seen this cycle, from whichever path carries them
   wire [6:0] raw_check = (state == ST_CHECK) ? mem_data_i[6:0] : chkbus_i[6:0];
   wire capture_field = sample_check & read_checkbit_bypass & prot_en;

   assign req_ready_o = state == ST_IDLE;

   // ****************************************************************
   // Next state
   // ****************************************************************
   always_comb begin
      next_state = state;
      unique case (state)
         ST_IDLE: begin
            if (req_valid_i) begin
               next_state = ST_DATA;
            end
         end
         ST_DATA: begin
            if (cyc_end && last_data) begin
               // 8-bit protected words fetch a fifth byte
               next_state = need_check_byte ? ST_CHECK : ST_DONE;
            end
         end
         ST_CHECK: begin
            if (cyc_end) begin
               next_state = ST_DONE;
            end
         end
         ST_DONE: begin
            next_state = ST_IDLE;
         end
         default: begin
            next_state = ST_IDLE;
         end
      endcase
   end

   // ****************************************************************
   // Sequencer registers
   // ****************************************************************
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         state <= ST_IDLE;
      end else begin
         state <= next_state;
      end
   end

   // Memory cycle and byte counters
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         cyc_cnt <= 2'h0;
         byte_cnt <= 2'h0;
      end else if (state == ST_IDLE) begin
         cyc_cnt <= 2'h0;
         byte_cnt <= 2'h0;
      end else if (cyc_end) begin
         cyc_cnt <= 2'h0;
         byte_cnt <= byte_cnt + 2'h1;
      end else begin
         cyc_cnt <= cyc_cnt + 2'h1;
      end
   end

   // Request latch, taken only when idle
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         is_write <= 1'b0;
         addr <= 28'h000_0000;
         wdata <= 32'h0000_0000;
      end else if (req_valid_i && state == ST_IDLE) begin
         is_write <= req_write_i;
         addr <= req_addr_i;
         wdata <= req_wdata_i;
      end
   end

   // Read data gathering; 8-bit mode fills one lane per memory cycle
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         rdata <= 32'h0000_0000;
      end else if (sample_data) begin
         if (bus8) begin
            rdata[byte_cnt*8 +: 8] <= mem_data_i[7:0];
         end else begin
            rdata <= mem_data_i;
         end
      end
   end

   // Raw check bits; unused path leaves zero, and the prot_en gating on the error terms keeps a disabled check from tripping
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         rcheck <= 7'h00;
      end else if (state == ST_IDLE) begin
         rcheck <= 7'h00;
      end else if (sample_check) begin
         rcheck <= raw_check;
      end
   end

   // ****************************************************************
   // Response to the master
   // ****************************************************************
   // Registered so data and error stand with the valid pulse
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         resp_valid_o <= 1'b0;
         resp_err_o <= 1'b0;
         resp_rdata_o <= 32'h0000_0000;
      end else begin
         resp_valid_o <= state == ST_DONE;
         resp_err_o <= (state == ST_DONE) & ~is_write & double_err;
         if (state == ST_DONE && !is_write) begin
            resp_rdata_o <= corr_data;
         end
      end
   end

   // ****************************************************************
   // Configuration, status and mask registers
   // ****************************************************************
   // Hardware capture of the test field loses to a software write;
   // the master keeps other traffic away while bypassing anyway
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         cfg3 <= `PECB_RST_CFG3;
      end else if (wr_cfg) begin
         cfg3 <= pwdata_i & cfg_wmask;
      end else if (capture_field) begin
         cfg3[`PECB_CFG_FIELD_HI:`PECB_CFG_FIELD_LO] <= raw_check;
      end
   end

   // Sticky events; a new event wins over the read that clears
   wire ev_corr = (state == ST_DONE) & ~is_write & single_err;
   wire ev_uncorr = (state == ST_DONE) & ~is_write & double_err;
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         status <= 2'h0;
      end else begin
         status <= (rd_st ? 2'h0 : status) | {ev_uncorr, ev_corr};
      end
   end

   // Interrupt mask
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         mask <= `PECB_RST_MASK;
      end else if (wr_mask) begin
         mask <= pwdata_i[1:0];
      end
   end

   // ****************************************************************
   // External memory drive
   // ****************************************************************
   wire active = (state == ST_DATA) | (state == ST_CHECK);
   wire [27:0] data_addr = bus8 ? {addr[27:2], byte_cnt} : {addr[27:2], 2'b00};
   wire [27:0] check_addr = {2'b00, ~addr[27:2]};
   assign mem_addr_o = (state == ST_CHECK) ? check_addr : data_addr;
   assign mem_cs_n_o = ~active;
   assign mem_oe_n_o = ~(active & ~is_write);
   assign mem_we_n_o = ~(active & is_write);
   assign mem_data_oe_o = active & is_write;
   // Check byte rides the data lane in 8-bit mode
   assign mem_data_o = (state == ST_CHECK) ? {25'h0, wr_check} :
                       bus8 ? {24'h0, wdata[byte_cnt*8 +: 8]} : wdata;
   assign chkbus_o = use_chkbus ? {1'b0, wr_check} : 8'h00;
   assign chkbus_oe_o = active & is_write & use_chkbus;

   // ****************************************************************
   // Assertions
   // ****************************************************************
   default clocking main_clk @(posedge core_clk_i);
   endclocking
   default disable iff (rst_i);

   sequence s_done_read;
      state == ST_DONE && !is_write;
   endsequence

   a_double_err_resp: assert property (
      s_done_read ##0 double_err |=> resp_valid_o && resp_err_o)
      else $error("double error not answered with error");
   a_single_no_err: assert property (
      s_done_read ##0 single_err |=> resp_valid_o && !resp_err_o
      && resp_rdata_o == $past(corr_data))
      else $error("single error not corrected cleanly");
   a_disabled_no_err: assert property (
      resp_valid_o && !$past(prot_en) |-> !resp_err_o)
      else $error("error reported with protection off");
   a_chkbus_unused: assert property (
      chkbus_oe_o |-> prot_en && !bus8)
      else $error("checkbit bus driven outside 32-bit protected mode");
   a_write_bypass: assert property (
      chkbus_oe_o && write_checkbit_bypass |-> chkbus_o[6:0] == test_field)
      else $error("write bypass value not driven");
   a_fresh_check: assert property (
      chkbus_oe_o && !write_checkbit_bypass |-> chkbus_o[6:0] == wcheck_gen)
      else $error("generated check bits not driven");
   a_read_capture: assert property (
      capture_field && !wr_cfg |=> test_field == $past(raw_check))
      else $error("read bypass capture missing");
   a_no_capture_off: assert property (
      !prot_en && !wr_cfg |=> $stable(test_field))
      else $error("test field changed with checking off");
   a_check_addr: assert property (
      state == ST_CHECK |-> mem_addr_o[25:0] == ~addr[27:2])
      else $error("check byte address not inverted");
   a_byte_words: assert property (
      $rose(state == ST_DATA) && bus8 && prot_en
      |-> ##(4 * `PECB_MEM_CYC) state == ST_CHECK)
      else $error("8-bit word not four bytes");

endmodule

// ---- verilog/pecb_regs.svh ----
// Register offsets, field positions, reset values and timing counts of the boot-memory checker
`ifndef PECB_REGS_SVH
`define PECB_REGS_SVH

// ****************************************************************
// Register byte offsets on the APB slave
// ****************************************************************
`define PECB_OFS_CFG3 12'h000
`define PECB_OFS_STATUS 12'h004
`define PECB_OFS_MASK 12'h008

// ****************************************************************
// Field positions of memory_config_reg_three
// ****************************************************************
`define PECB_CFG_PROT_EN 0
`define PECB_CFG_WR_BYP 1
`define PECB_CFG_RD_BYP 2
`define PECB_CFG_BUS8 3
`define PECB_CFG_FIELD_LO 8
`define PECB_CFG_FIELD_HI 14

// ****************************************************************
// Status and mask bit positions
// ****************************************************************
`define PECB_ST_CORR 0
`define PECB_ST_UNCORR 1

// ****************************************************************
// Reset values
// ****************************************************************
`define PECB_RST_CFG3 32'h0000_0000
`define PECB_RST_MASK 2'h0

// ****************************************************************
// Timing: memory cycle length in ns and in core clock cycles
// ****************************************************************
`define PECB_CLK_NS 8
`define PECB_MEM_CYC_NS 16
`define PECB_MEM_CYC ((`PECB_MEM_CYC_NS + `PECB_CLK_NS - 1) / `PECB_CLK_NS)

`endif

// ---- verilog/pecb_pkg.sv ----
// Types and code-column helper of the boot-memory checker
package pecb_pkg;

   // Seven check bits per 32-bit word
   typedef logic [6:0] pecb_check_t;

   // Sequencer states, one-hot
   typedef enum logic [3:0] {
      ST_IDLE = 4'b0001,
      ST_DATA = 4'b0010,
      ST_CHECK = 4'b0100,
      ST_DONE = 4'b1000
   } pecb_state_e;

   // Column of data bit idx: the idx-th seven-bit value of weight three
   function automatic pecb_check_t pecb_col(input int idx);
      int cnt;
      pecb_check_t res;
      cnt = 0;
      res = 7'h00;
      for (int v = 0; v < 128; v++) begin
         if ($countones(v[6:0]) == 3) begin
            if (cnt == idx) begin
               res = v[6:0];
            end
            cnt++;
         end
      end
      return res;
   endfunction

endpackage

// ---- verilog/pecb_check_gen.sv ----
// Check-bit generator: seven parities over a 32-bit word
module pecb_check_gen
   import pecb_pkg::*;
(
   input wire logic [31:0] data_i,
   output pecb_check_t check_o
);

   // ****************************************************************
   // Parity trees
   // ****************************************************************
   // Each check bit covers the data bits whose column has that bit set
   always_comb begin
      check_o = 7'h00;
      for (int i = 0; i < 32; i++) begin
         check_o = check_o ^ (pecb_col(i) & {7{data_i[i]}});
      end
   end

endmodule

// ---- sim/pecb_mem_model.sv ----
// External boot memory model: word-wide data beside a checkbit device, or byte-wide
module pecb_mem_model (
   input wire logic core_clk_i,
   input wire logic bus8_i, // Byte-wide wiring
   input wire logic [27:0] mem_addr_i,
   input wire logic mem_cs_n_i,
   input wire logic mem_oe_n_i,
   input wire logic mem_we_n_i,
   input wire logic [31:0] wdata_i,
   input wire logic wdata_oe_i,
   input wire logic [7:0] chkbus_i,
   input wire logic chkbus_oe_i,
   input wire logic [31:0] flip_i, // Read corruption asked for by the bench
   input wire logic [6:0] chkbus_flip_i,
   output logic [31:0] rdata_o,
   output logic [7:0] chkbus_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [31:0] word_mem [int]; // Word store keyed by pin address
   logic [7:0] byte_mem [int]; // Byte store for byte-wide wiring
   logic [7:0] chk_mem [int]; // Parallel checkbit device
   initial begin
      rdata_o = 32'h0;
      chkbus_o = 8'h00;
   end
   // ******************************************
   // Write: an undriven bus stores unknowns, so a missing enable shows up
   // ******************************************
   always @(posedge core_clk_i) begin
      if (!mem_cs_n_i && !mem_we_n_i) begin
         if (bus8_i) begin
            byte_mem[int'(mem_addr_i)] = wdata_oe_i ? wdata_i[7:0] : 8'hXX;
         end else begin
            word_mem[int'(mem_addr_i)] = wdata_oe_i ? wdata_i : 32'hXXXX_XXXX;
            chk_mem[int'(mem_addr_i)] = chkbus_oe_i ? chkbus_i : 8'hXX;
         end
      end
   end
   // ******************************************
   // Read: half a cycle access; released lines show the inverse of the last value
   // ******************************************
   always @(negedge core_clk_i) begin
      if (!mem_cs_n_i && !mem_oe_n_i && bus8_i) begin
         rdata_o[31:8] <= ~rdata_o[31:8];
         rdata_o[7:0] <= byte_mem.exists(int'(mem_addr_i)) ? byte_mem[int'(mem_addr_i)] : 8'hA5;
         chkbus_o <= ~chkbus_o;
      end else if (!mem_cs_n_i && !mem_oe_n_i) begin
         rdata_o <= word_mem[int'(mem_addr_i)] ^ flip_i;
         chkbus_o <= chk_mem[int'(mem_addr_i)] ^ {1'b0, chkbus_flip_i};
      end else begin
         rdata_o <= ~rdata_o;
         chkbus_o <= ~chkbus_o;
      end
   end
endmodule

// ---- sim/pecb_core_bench.sv ----
// Self-checking bench of the boot-memory error correction path
`include "pecb_regs.svh"
module pecb_core_bench;
   timeunit 1ns;
   timeprecision 1ps;
   logic core_clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
   logic [11:0] paddr_i = 12'h000;
   logic [31:0] pwdata_i = 32'h0, req_wdata_i = 32'h0, flip = 32'h0;
   logic req_valid_i = 1'b0, req_write_i = 1'b0, bus8 = 1'b0, chkbus_seen = 1'b0;
   logic [27:0] req_addr_i = 28'h0;
   logic [6:0] chkbus_flip = 7'h00;
   wire logic [31:0] prdata_o, resp_rdata_o, mem_data_o, mem_data_i;
   wire logic pready_o, pslverr_o, irq_o, req_ready_o, resp_valid_o, resp_err_o;
   wire logic mem_cs_n_o, mem_oe_n_o, mem_we_n_o, mem_data_oe_o, chkbus_oe_o;
   wire logic [27:0] mem_addr_o;
   wire logic [7:0] chkbus_i, chkbus_o;
   int errors = 0, check_count = 0;
   always #4 core_clk_i = ~core_clk_i;
   always @(negedge core_clk_i) if (chkbus_oe_o === 1'b1) chkbus_seen <= 1'b1;
   pecb_core DUT (.core_clk_i, .rst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
      .prdata_o, .pready_o, .pslverr_o, .irq_o, .req_valid_i, .req_write_i, .req_addr_i,
      .req_wdata_i, .req_ready_o, .resp_valid_o, .resp_err_o, .resp_rdata_o, .mem_addr_o,
      .mem_cs_n_o, .mem_oe_n_o, .mem_we_n_o, .mem_data_i, .mem_data_o, .mem_data_oe_o,
      .chkbus_i, .chkbus_o, .chkbus_oe_o);
   pecb_mem_model MEM (.core_clk_i(core_clk_i), .bus8_i(bus8), .mem_addr_i(mem_addr_o),
      .mem_cs_n_i(mem_cs_n_o), .mem_oe_n_i(mem_oe_n_o), .mem_we_n_i(mem_we_n_o),
      .wdata_i(mem_data_o), .wdata_oe_i(mem_data_oe_o), .chkbus_i(chkbus_o),
      .chkbus_oe_i(chkbus_oe_o), .flip_i(flip), .chkbus_flip_i(chkbus_flip),
      .rdata_o(mem_data_i), .chkbus_o(chkbus_i));
   // ******************************************
   // Reference model and comparisons
   // ******************************************
   // Check value: data bit k uses the k-th weight-three column in ascending order
   function automatic logic [6:0] chk(input logic [31:0] d);
      logic [6:0] res;
      int k;
      res = 7'h00;
      k = 0;
      for (int v = 1; v < 128; v++) begin
         if ($countones(v) == 3) begin
            if (k < 32 && d[k]) res ^= 7'(v);
            k++;
         end
      end
      return res;
   endfunction
   function automatic logic [27:0] addr();
      return {18'h0, 8'($urandom), 2'b00};
   endfunction
   task automatic cmp_word(input string nm, input logic [31:0] exp, input logic [31:0] got);
      check_count++;
      if (got !== exp) begin
         errors++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic cmp_flag(input string nm, input logic exp, input logic got);
      check_count++;
      if (got !== exp) begin
         errors++;
         $display("MISMATCH %s expected %b seen %b", nm, exp, got);
      end
   endtask
   // ******************************************
   // Bus tasks: apb holds each access until pready_o is sampled; xfer holds the request only until req_ready_o, then waits for the answer
   // ******************************************
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
      output logic [31:0] rd, output logic er);
      int n;
      n = 0;
      @(posedge core_clk_i);
      psel_i <= 1'b1;
      pwrite_i <= wr;
      paddr_i <= a;
      pwdata_i <= wd;
      @(posedge core_clk_i);
      penable_i <= 1'b1;
      // Answer taken at the very edge that samples pready high
      do begin @(posedge core_clk_i); n++; end while (pready_o !== 1'b1 && n < 50);
      if (n >= 50) errors++;
      rd = prdata_o;
      er = pslverr_o;
      psel_i <= 1'b0;
      penable_i <= 1'b0;
   endtask
   // Sole master on the request port, so bypass state never sees a stray access
   task automatic xfer(input logic wr, input logic [27:0] a, input logic [31:0] wd,
      output logic [31:0] rd, output logic er);
      int n;
      n = 0;
      @(posedge core_clk_i);
      req_valid_i <= 1'b1;
      req_write_i <= wr;
      req_addr_i <= a;
      req_wdata_i <= wd;
      do begin @(posedge core_clk_i); n++; end while (req_ready_o !== 1'b1 && n < 100);
      req_valid_i <= 1'b0;
      do begin @(posedge core_clk_i); n++; end while (resp_valid_o !== 1'b1 && n < 200);
      if (n >= 200) errors++;
      rd = resp_rdata_o;
      er = resp_err_o;
   endtask
   task automatic print_verdict();
      $display("Comparisons %0d, mismatches %0d", check_count, errors);
      if (errors == 0 && check_count > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   // Watchdog well beyond the few hundred cycles the sequence needs
   initial begin
      #200000;
      errors++;
      print_verdict();
   end
   initial begin
      logic [31:0] d, r, w;
      logic e;
      logic [27:0] a;
      int b;
      void'($urandom(32'h163d));
      repeat (8) @(posedge core_clk_i);
      rst_i <= 1'b0;
      // Reset values, then an unmapped offset
      apb(1'b0, `PECB_OFS_CFG3, 32'h0, r, e);
      cmp_word("cfg3", `PECB_RST_CFG3, r);
      apb(1'b0, `PECB_OFS_MASK, 32'h0, r, e);
      cmp_word("mask", 32'(`PECB_RST_MASK), r);
      apb(1'b0, 12'h00C, 32'h0, r, e);
      cmp_flag("slverr", 1'b1, e);
      // Protection off: raw data back, never an error, checkbit bus idle
      a = addr();
      d = $urandom;
      xfer(1'b1, a, d, r, e);
      flip <= 32'h0000_0011;
      xfer(1'b0, a, 32'h0, r, e);
      cmp_word("raw rdata", d ^ 32'h11, r);
      cmp_flag("err off", 1'b0, e);
      cmp_flag("chkbus idle", 1'b0, chkbus_seen);
      // Protection on, word-wide: single errors corrected, double errors refused
      apb(1'b1, `PECB_OFS_CFG3, 32'h1, r, e);
      for (int i = 0; i < 4; i++) begin
         a = addr();
         d = $urandom;
         b = $urandom_range(31, 0);
         flip <= 32'h0;
         xfer(1'b1, a, d, r, e);
         cmp_word("stored check", 32'(chk(d)), 32'(MEM.chk_mem[int'(a)]));
         flip <= 32'h1 << b;
         xfer(1'b0, a, 32'h0, r, e);
         cmp_word("corrected", d, r);
         cmp_flag("err single", 1'b0, e);
         flip <= 32'h0;
         chkbus_flip <= 7'h01 << i;
         xfer(1'b0, a, 32'h0, r, e);
         cmp_word("check bit error", d, r);
         chkbus_flip <= 7'h00;
         flip <= 32'h3 << (b % 31);
         xfer(1'b0, a, 32'h0, r, e);
         cmp_flag("err double", 1'b1, e);
      end
      flip <= 32'h0;
      // Sticky status, mask, level interrupt, clear on read
      cmp_flag("irq masked", 1'b0, irq_o);
      apb(1'b1, `PECB_OFS_MASK, 32'h2, r, e);
      @(negedge core_clk_i);
      cmp_flag("irq on", 1'b1, irq_o);
      apb(1'b0, `PECB_OFS_STATUS, 32'h0, r, e);
      cmp_word("status", 32'h3, r);
      @(negedge core_clk_i);
      cmp_flag("irq clear", 1'b0, irq_o);
      // Write bypass puts an arbitrary value on the checkbit bus, as a flash command does
      w = 32'($urandom_range(127, 0));
      apb(1'b1, `PECB_OFS_CFG3, 32'h3 | (w << 8), r, e);
      a = addr();
      xfer(1'b1, a, $urandom, r, e);
      cmp_word("bypass check", w, 32'(MEM.chk_mem[int'(a)]));
      apb(1'b0, `PECB_OFS_CFG3, 32'h0, r, e);
      cmp_word("field held", 32'h3 | (w << 8), r);
      // Read bypass captures the raw check bits; an error answer is tolerated
      apb(1'b1, `PECB_OFS_CFG3, 32'h5, r, e);
      xfer(1'b0, a, 32'h0, r, e);
      apb(1'b0, `PECB_OFS_CFG3, 32'h0, r, e);
      cmp_word("field capture", 32'h5 | (w << 8), r);
      // Capture is inert with protection off
      apb(1'b1, `PECB_OFS_CFG3, 32'h5504, r, e);
      xfer(1'b0, a, 32'h0, r, e);
      apb(1'b0, `PECB_OFS_CFG3, 32'h0, r, e);
      cmp_word("field inert", 32'h5504, r);
      // Byte-wide with protection: four bytes, check byte at the inverted word address
      apb(1'b1, `PECB_OFS_CFG3, 32'h9, r, e);
      bus8 <= 1'b1;
      chkbus_seen <= 1'b0;
      a = addr();
      d = $urandom;
      xfer(1'b1, a, d, r, e);
      for (int n = 0; n < 4; n++) begin
         cmp_word("byte", 32'(d[8*n+:8]), 32'(MEM.byte_mem[int'(a) + n]));
      end
      cmp_word("check byte", 32'(chk(d)), 32'(MEM.byte_mem[int'({2'b00, ~a[27:2]})]));
      xfer(1'b0, a, 32'h0, r, e);
      cmp_word("rdata 8", d, r);
      cmp_flag("err 8", 1'b0, e);
      cmp_flag("chkbus idle 8", 1'b0, chkbus_seen);
      print_verdict();
   end
endmodule
